// [core/iapg_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

// shift-style buffer: head always sits in slot 0 so every output is a flop
module iapg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    // filling side
    input  wire logic             inValid,
    output var  logic             inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output var  logic             outValid,
    input  wire logic             outReady,
    output var  logic [WIDTH-1:0] outData
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] slot [0:DEPTH-1];
    logic [CW-1:0]    count;
    logic             push;
    logic             pop;
    logic [CW-1:0]    next_count;

    assign push = inValid && inReady;
    assign pop  = outValid && outReady;
    assign next_count = count + CW'(push) - CW'(pop);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count    <= '0;
            inReady  <= 1'b1;
            outValid <= 1'b0;
        end else begin
            count    <= next_count;
            inReady  <= next_count != CW'(DEPTH);
            outValid <= next_count != '0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_slot
            always_ff @(posedge sys_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    slot[i] <= '0;
                end else if (push && CW'(i) == count - CW'(pop)) begin
                    slot[i] <= inData;
                end else if (pop && i < DEPTH - 1) begin
                    slot[i] <= slot[(i < DEPTH - 1) ? i + 1 : i];
                end
            end
        end
    endgenerate

    assign outData = slot[0];

endmodule : iapg_fifo

`default_nettype wire

// [core/iapg_pkg.sv]
package iapg_pkg;

    typedef enum logic [3:0] {
        PG_DIGITAL = 4'b0000,
        PG_CHAN0   = 4'b0001,
        PG_CHAN1   = 4'b0010,
        PG_RSVD3   = 4'b0011,
        PG_RSVD4   = 4'b0100,
        PG_SHARE   = 4'b0101,
        PG_ALLCHAN = 4'b0110,
        PG_CSIT    = 4'b0111
    } iapg_page_e;

    typedef enum logic [0:0] {
        GEN_IDLE = 1'b0,
        GEN_RUN  = 1'b1
    } iapg_gen_e;

endpackage : iapg_pkg

// [core/iapg_regs.svh]
`ifndef IAPG_REGS_SVH
`define IAPG_REGS_SVH

// main-space addresses of the indirect access port
`define IAPG_ADDR_CTL       8'hB0
`define IAPG_ADDR_OFF       8'hB1
`define IAPG_ADDR_DATA      8'hB2

// indirect_control fields
`define IAPG_CTL_AUTOINC    1
`define IAPG_CTL_PAGE_MSB   5
`define IAPG_CTL_PAGE_LSB   2
`define IAPG_RST_CTL        8'h00
`define IAPG_RST_OFF        8'h00

// page 0 offsets
`define IAPG_OFF_RSVD       8'h00
`define IAPG_OFF_CTRL       8'h01
`define IAPG_OFF_CFG        8'h02
`define IAPG_OFF_IDENT      8'h03
`define IAPG_OFF_LINE_HI    8'h04
`define IAPG_OFF_LINE_LO    8'h05
`define IAPG_OFF_BAR_HI     8'h06
`define IAPG_OFF_BAR_LO     8'h07
`define IAPG_OFF_MISC_FIRST 8'h08
`define IAPG_OFF_GEN_LAST   8'h1F
`define IAPG_OFF_TIM_FIRST  8'h40
`define IAPG_OFF_TIM_LAST   8'h48

// last offsets of the test pages
`define IAPG_OFF_CHAN_LAST  8'h14
`define IAPG_OFF_SHARE_LAST 8'h04
`define IAPG_OFF_CSIT_LAST  8'h1D

// page 0 reset values
`define IAPG_RST_CTRL       8'h00
`define IAPG_RST_CFG        8'h33
`define IAPG_RST_IDENT      8'h24
`define IAPG_RST_LINE_HI    8'h07
`define IAPG_RST_LINE_LO    8'h80
`define IAPG_RST_BAR_HI     8'h00
`define IAPG_RST_BAR_LO     8'hF0
`define IAPG_RST_BYTE       8'h00

// page 0 field positions
`define IAPG_CTRL_ON        0
`define IAPG_CFG_FIXED      7
`define IAPG_CFG_BARS_MSB   5
`define IAPG_CFG_BARS_LSB   4
`define IAPG_CFG_BLK_MSB    3
`define IAPG_CFG_BLK_LSB    0
`define IAPG_ID_VC_MSB      7
`define IAPG_ID_VC_LSB      6
`define IAPG_ID_DT_MSB      5
`define IAPG_ID_DT_LSB      0

// pattern byte stream buffer
`define IAPG_FIFO_WIDTH     9
`define IAPG_FIFO_DEPTH     8

`endif

// [core/iapg_top.sv]
// Function
// - control, offset and data registers sit at main addresses 0xB0 to 0xB2.
// - control bits 5:2 pick the indirect page from eight documented codes.
// - host writes page, offset, then data; device stores byte there.
// - host writes page and offset, reads data; device returns that location.
// - with auto-increment set, offset advances after each data access.
// - page 0 decodes generator offsets 0x01-0x1F and timing 0x40-0x48.
// - channel test pages span 0x00-0x14, shared 0x00-0x04, transmitter 0x00-0x1D.
// - page 0 offset 0x00 is reserved, read-only and reads zero.
// - page 0 offset 0x01 bit 0 enables the generator, reset off.
// - config bit 7 picks colour bars or fixed patterns, reset bars.
// - config bits 5:4 pick one, two, four or eight bars, reset eight.
// - config bits 3:0 give fixed block size 1 to 15, reset 3.
// - offset 0x03 bits 7:6 give packet virtual channel, reset 0.
// - offset 0x03 bits 5:0 give packet data type, reset 0x24.
// - line length is 16 bits at offsets 0x04 and 0x05, reset 0x0780.
// - all bars but last span bar length; last takes the rest.
`timescale 1ns/1ps
`default_nettype none
`include "iapg_regs.svh"

module iapg_top
    import iapg_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // main register port
    input  wire logic [7:0]  regAddr,
    input  wire logic        regWrEn,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regRdEn,
    output var  logic [7:0]  regRdData,
    output var  logic        regRdValid,
    // generator settings
    output var  logic        testgenOn,
    output var  logic        fixedPatternSelect,
    output var  logic [1:0]  barCount,
    output var  logic [3:0]  blockSize,
    output var  logic [1:0]  genVirtualChannel,
    output var  logic [5:0]  genDataType,
    output var  logic [15:0] activeLineBytes,
    output var  logic [15:0] barLengthBytes,
    // pattern byte stream
    output var  logic        pixValid,
    input  wire logic        pixReady,
    output var  logic [7:0]  pixData,
    output var  logic        pixLast
);

    function automatic logic mapped(input logic [3:0] pg, input logic [7:0] off);
        unique case (iapg_page_e'(pg))
            PG_DIGITAL: mapped = (off >= `IAPG_OFF_CTRL && off <= `IAPG_OFF_GEN_LAST)
                              || (off >= `IAPG_OFF_TIM_FIRST && off <= `IAPG_OFF_TIM_LAST);
            PG_CHAN0, PG_CHAN1, PG_ALLCHAN: mapped = off <= `IAPG_OFF_CHAN_LAST;
            PG_SHARE:   mapped = off <= `IAPG_OFF_SHARE_LAST;
            PG_CSIT:    mapped = off <= `IAPG_OFF_CSIT_LAST;
            default:    mapped = 1'b0;
        endcase
    endfunction : mapped

    logic [7:0] indirectControl;
    logic [7:0] indirectOffset;
    logic [3:0] pageSelect;
    logic       autoInc;
    logic       dataWr;
    logic       dataRd;
    logic       hit;
    logic [7:0] rdByte;

    logic [7:0] testgenControl;
    logic [7:0] testgenConfig;
    logic [7:0] testgenPacketIdent;
    logic [7:0] lineHigh;
    logic [7:0] lineLow;
    logic [7:0] barHigh;
    logic [7:0] barLow;
    logic [7:0] genMisc  [0:23];
    logic [7:0] timReg   [0:8];
    logic [7:0] chanReg  [0:1][0:20];
    logic [7:0] shareReg [0:4];
    logic [7:0] csitReg  [0:29];

    assign pageSelect = indirectControl[`IAPG_CTL_PAGE_MSB:`IAPG_CTL_PAGE_LSB];
    assign autoInc    = indirectControl[`IAPG_CTL_AUTOINC];
    assign dataWr     = regWrEn && regAddr == `IAPG_ADDR_DATA;
    assign dataRd     = regRdEn && regAddr == `IAPG_ADDR_DATA;
    assign hit        = mapped(pageSelect, indirectOffset);

    // direct registers of the main map
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            indirectControl <= `IAPG_RST_CTL;
        end else if (regWrEn && regAddr == `IAPG_ADDR_CTL) begin
            indirectControl <= regWrData;
        end
    end

    // a direct offset write beats the increment of the same cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            indirectOffset <= `IAPG_RST_OFF;
        end else if (regWrEn && regAddr == `IAPG_ADDR_OFF) begin
            indirectOffset <= regWrData;
        end else if (autoInc && (dataWr || dataRd)) begin
            indirectOffset <= indirectOffset + 8'h01;
        end
    end

    // read mux; anything unmapped, reserved page or page 0 offset 0 gives zero
    always_comb begin
        rdByte = 8'h00;
        if (hit) begin
            unique case (iapg_page_e'(pageSelect))
                PG_DIGITAL: begin
                    if (indirectOffset >= `IAPG_OFF_TIM_FIRST) begin
                        rdByte = timReg[indirectOffset[3:0]];
                    end else begin
                        unique case (indirectOffset)
                            `IAPG_OFF_CTRL:    rdByte = testgenControl;
                            `IAPG_OFF_CFG:     rdByte = testgenConfig;
                            `IAPG_OFF_IDENT:   rdByte = testgenPacketIdent;
                            `IAPG_OFF_LINE_HI: rdByte = lineHigh;
                            `IAPG_OFF_LINE_LO: rdByte = lineLow;
                            `IAPG_OFF_BAR_HI:  rdByte = barHigh;
                            `IAPG_OFF_BAR_LO:  rdByte = barLow;
                            default: rdByte = genMisc[indirectOffset[4:0] - 5'h08];
                        endcase
                    end
                end
                PG_CHAN0, PG_ALLCHAN: rdByte = chanReg[0][indirectOffset[4:0]];
                PG_CHAN1: rdByte = chanReg[1][indirectOffset[4:0]];
                PG_SHARE: rdByte = shareReg[indirectOffset[2:0]];
                PG_CSIT:  rdByte = csitReg[indirectOffset[4:0]];
                default:  rdByte = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (dataRd) begin
                regRdData <= rdByte;
            end else if (regRdEn && regAddr == `IAPG_ADDR_CTL) begin
                regRdData <= indirectControl;
            end else if (regRdEn && regAddr == `IAPG_ADDR_OFF) begin
                regRdData <= indirectOffset;
            end else begin
                regRdData <= 8'h00;
            end
        end
    end

    // page 0 generator settings
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            testgenControl     <= `IAPG_RST_CTRL;
            testgenConfig      <= `IAPG_RST_CFG;
            testgenPacketIdent <= `IAPG_RST_IDENT;
            lineHigh           <= `IAPG_RST_LINE_HI;
            lineLow            <= `IAPG_RST_LINE_LO;
            barHigh            <= `IAPG_RST_BAR_HI;
            barLow             <= `IAPG_RST_BAR_LO;
            for (int k = 0; k < 24; k++) genMisc[k] <= `IAPG_RST_BYTE;
            for (int k = 0; k < 9; k++) timReg[k] <= `IAPG_RST_BYTE;
        end else if (dataWr && hit && pageSelect == PG_DIGITAL) begin
            if (indirectOffset >= `IAPG_OFF_TIM_FIRST) begin
                timReg[indirectOffset[3:0]] <= regWrData;
            end else begin
                unique case (indirectOffset)
                    `IAPG_OFF_CTRL:    testgenControl     <= regWrData;
                    `IAPG_OFF_CFG:     testgenConfig      <= regWrData;
                    `IAPG_OFF_IDENT:   testgenPacketIdent <= regWrData;
                    `IAPG_OFF_LINE_HI: lineHigh           <= regWrData;
                    `IAPG_OFF_LINE_LO: lineLow            <= regWrData;
                    `IAPG_OFF_BAR_HI:  barHigh            <= regWrData;
                    `IAPG_OFF_BAR_LO:  barLow             <= regWrData;
                    default: genMisc[indirectOffset[4:0] - 5'h08] <= regWrData;
                endcase
            end
        end
    end

    // test pages; the write-all page lands in both channels
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < 21; k++) chanReg[c][k] <= `IAPG_RST_BYTE;
            end
            for (int k = 0; k < 5; k++) shareReg[k] <= `IAPG_RST_BYTE;
            for (int k = 0; k < 30; k++) csitReg[k] <= `IAPG_RST_BYTE;
        end else if (dataWr && hit) begin
            if (pageSelect == PG_CHAN0 || pageSelect == PG_ALLCHAN) begin
                chanReg[0][indirectOffset[4:0]] <= regWrData;
            end
            if (pageSelect == PG_CHAN1 || pageSelect == PG_ALLCHAN) begin
                chanReg[1][indirectOffset[4:0]] <= regWrData;
            end
            if (pageSelect == PG_SHARE) begin
                shareReg[indirectOffset[2:0]] <= regWrData;
            end
            if (pageSelect == PG_CSIT) begin
                csitReg[indirectOffset[4:0]] <= regWrData;
            end
        end
    end

    assign testgenOn          = testgenControl[`IAPG_CTRL_ON];
    assign fixedPatternSelect = testgenConfig[`IAPG_CFG_FIXED];
    assign barCount           = testgenConfig[`IAPG_CFG_BARS_MSB:`IAPG_CFG_BARS_LSB];
    assign blockSize          = testgenConfig[`IAPG_CFG_BLK_MSB:`IAPG_CFG_BLK_LSB];
    assign genVirtualChannel  = testgenPacketIdent[`IAPG_ID_VC_MSB:`IAPG_ID_VC_LSB];
    assign genDataType        = testgenPacketIdent[`IAPG_ID_DT_MSB:`IAPG_ID_DT_LSB];
    assign activeLineBytes    = {lineHigh, lineLow};
    assign barLengthBytes     = {barHigh, barLow};

    // byte generator feeding the buffer
    iapg_gen_e  genState;
    logic [15:0] bytePos;
    logic [15:0] barPos;
    logic [2:0]  barIdx;
    logic [2:0]  barMax;
    logic [3:0]  blkPos;
    logic [3:0]  blkLen;
    logic        blkIdx;
    logic        genPush;
    logic        fifoReady;
    logic        lineEnd;
    logic [7:0]  genByte;

    assign barMax  = 3'((4'h1 << barCount) - 4'h1);
    assign blkLen  = (blockSize == 4'h0) ? 4'h1 : blockSize; // size 0 is illegal, run as 1
    assign lineEnd = bytePos == activeLineBytes - 16'h0001;
    assign genPush = genState == GEN_RUN && fifoReady;
    assign genByte = fixedPatternSelect ? {8{blkIdx}} : {5'h00, barIdx};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            genState <= GEN_IDLE;
        end else begin
            unique case (genState)
                GEN_IDLE: if (testgenOn) genState <= GEN_RUN;
                GEN_RUN:  if (!testgenOn) genState <= GEN_IDLE;
            endcase
        end
    end

    // counters restart while idle so each enable begins a fresh line
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bytePos <= 16'h0000;
            barPos  <= 16'h0000;
            barIdx  <= 3'h0;
            blkPos  <= 4'h0;
            blkIdx  <= 1'b0;
        end else if (genState == GEN_IDLE || (genPush && lineEnd)) begin
            bytePos <= 16'h0000;
            barPos  <= 16'h0000;
            barIdx  <= 3'h0;
            blkPos  <= 4'h0;
            blkIdx  <= 1'b0;
        end else if (genPush) begin
            bytePos <= bytePos + 16'h0001;
            if (barPos == barLengthBytes - 16'h0001 && barIdx != barMax) begin
                barPos <= 16'h0000;
                barIdx <= barIdx + 3'h1;
            end else begin
                barPos <= barPos + 16'h0001;
            end
            if (blkPos == blkLen - 4'h1) begin
                blkPos <= 4'h0;
                blkIdx <= !blkIdx;
            end else begin
                blkPos <= blkPos + 4'h1;
            end
        end
    end

    iapg_fifo #(
        .WIDTH(`IAPG_FIFO_WIDTH),
        .DEPTH(`IAPG_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .inValid  (genPush),
        .inReady  (fifoReady),
        .inData   ({lineEnd, genByte}),
        .outValid (pixValid),
        .outReady (pixReady),
        .outData  ({pixLast, pixData})
    );

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence sDataWrite;
        dataWr && !autoInc && hit;
    endsequence
    sequence sReadBack;
        dataRd && !regWrEn;
    endsequence

    AST_RD_LATENCY: assert property (regRdEn |=> regRdValid)
        else $error("read answer missing one cycle after request");
    AST_AUTOINC: assert property ((dataWr || dataRd) && autoInc
        && !(regWrEn && regAddr == `IAPG_ADDR_OFF)
        |=> indirectOffset == $past(indirectOffset) + 8'h01)
        else $error("offset did not advance after data access");
    AST_NOINC: assert property ((dataWr || dataRd) && !autoInc && !regWrEn
        |=> $stable(indirectOffset))
        else $error("offset moved without auto-increment");
    // the host always leaves one idle cycle between strobes
    AST_WRITE_READ: assert property (sDataWrite ##1 !regWrEn ##1 sReadBack
        |=> regRdData == $past(regWrData, 3))
        else $error("written byte not returned on read back");
    AST_UNMAPPED_ZERO: assert property (dataRd && !hit |=> regRdData == 8'h00)
        else $error("unmapped location returned nonzero");
    AST_RSVD_ZERO: assert property (dataRd && pageSelect == PG_DIGITAL
        && indirectOffset == `IAPG_OFF_RSVD |=> regRdData == 8'h00)
        else $error("page 0 reserved offset returned nonzero");
    AST_PAGE_SELECT: assert property (regWrEn && regAddr == `IAPG_ADDR_CTL
        |=> pageSelect == $past(regWrData[`IAPG_CTL_PAGE_MSB:`IAPG_CTL_PAGE_LSB]))
        else $error("page select not taken from control write");
    AST_LAST_BAR: assert property (barIdx <= barMax || $changed(barCount))
        else $error("bar index passed the last bar");
    AST_IDLE_STOPS: assert property (!testgenOn ##1 !testgenOn |-> !genPush)
        else $error("generator pushed while disabled");

endmodule : iapg_top

`default_nettype wire

// [tb/iapg_host.sv]
`timescale 1ns/1ps
`default_nettype none

module iapg_host (
    // clock
    input  wire logic       sys_clk,
    // main register port
    output var  logic [7:0] regAddr,
    output var  logic       regWrEn,
    output var  logic [7:0] regWrData,
    output var  logic       regRdEn,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid
);
    initial begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end

    // one-cycle strobe; released lines show the inverse, not the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge sys_clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge sys_clk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge sys_clk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
        v = regRdValid;
    endtask : rd
endmodule : iapg_host

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "iapg_regs.svh"

module tb;
    import iapg_pkg::*;

    logic        sys_clk;
    logic        sys_rst;
    logic [7:0]  regAddr;
    logic        regWrEn;
    logic [7:0]  regWrData;
    logic        regRdEn;
    logic [7:0]  regRdData;
    logic        regRdValid;
    logic        testgenOn;
    logic        fixedPatternSelect;
    logic [1:0]  barCount;
    logic [3:0]  blockSize;
    logic [1:0]  genVirtualChannel;
    logic [5:0]  genDataType;
    logic [15:0] activeLineBytes;
    logic [15:0] barLengthBytes;
    logic        pixValid;
    logic        pixReady;
    logic [7:0]  pixData;
    logic        pixLast;
    logic [7:0]  rdVal;
    logic        rdOk;
    int          mem [16][256];
    int          offs [12] = '{8'h00, 8'h04, 8'h05, 8'h14, 8'h15, 8'h1D, 8'h1E, 8'h1F,
                               8'h20, 8'h40, 8'h48, 8'h49};
    int          ctl;
    int          off;
    int          pos;
    int          taken;
    int          lineLen;
    int          barLen;
    int          readyMode;
    bit          streamChk;
    int          mismatches;
    int          compares;

    iapg_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid), .testgenOn(testgenOn), .fixedPatternSelect(fixedPatternSelect),
        .barCount(barCount), .blockSize(blockSize), .genVirtualChannel(genVirtualChannel),
        .genDataType(genDataType), .activeLineBytes(activeLineBytes),
        .barLengthBytes(barLengthBytes), .pixValid(pixValid), .pixReady(pixReady),
        .pixData(pixData), .pixLast(pixLast));

    iapg_host host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .regRdValid(regRdValid));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] got, input int exp);
        compares++;
        if (got !== 16'(exp)) begin
            mismatches++;
            $display("Error t=%0t got %h exp %h", $time, got, 16'(exp));
        end
    endtask : check

    function automatic bit mapped(input int p, input int o);
        case (p)
            0: return (o >= 1 && o <= 8'h1F) || (o >= 8'h40 && o <= 8'h48);
            1, 2, 6: return o <= 8'h14;
            5: return o <= 8'h04;
            7: return o <= 8'h1D;
            default: return 1'b0;
        endcase
    endfunction : mapped

    task automatic sel(input int p, input int inc);
        ctl = p * 4 + inc * 2;
        host.wr(`IAPG_ADDR_CTL, 8'(ctl));
    endtask : sel

    task automatic setoff(input int o);
        off = o;
        host.wr(`IAPG_ADDR_OFF, 8'(o));
    endtask : setoff

    task automatic dwr(input logic [7:0] d);
        int p;
        p = (ctl >> 2) & 15;
        host.wr(`IAPG_ADDR_DATA, d);
        if (p == 6 && mapped(6, off)) begin
            mem[1][off] = d;
            mem[2][off] = d;
        end else if (p != 6 && mapped(p, off)) begin
            mem[p][off] = d;
        end
        if (ctl & 2) off = (off + 1) % 256;
    endtask : dwr

    task automatic drd();
        int p;
        int e;
        p = (ctl >> 2) & 15;
        e = !mapped(p, off) ? 0 : (p == 6 ? mem[1][off] : mem[p][off]);
        host.rd(`IAPG_ADDR_DATA, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256 + e);
        if (ctl & 2) off = (off + 1) % 256;
    endtask : drd

    task automatic chkOuts();
        int c;
        c = mem[0][2];
        check({15'h0000, testgenOn}, mem[0][1] & 1);
        check({8'h00, fixedPatternSelect, 1'b0, barCount, blockSize}, c & 191);
        check({8'h00, genVirtualChannel, genDataType}, mem[0][3]);
        check(activeLineBytes, mem[0][4] * 256 + mem[0][5]);
        check(barLengthBytes, mem[0][6] * 256 + mem[0][7]);
    endtask : chkOuts

    function automatic int expByte(input int i);
        int n;
        int b;
        int v;
        n = 1 << ((mem[0][2] >> 4) & 3);
        b = (mem[0][2] & 15) == 0 ? 1 : mem[0][2] & 15;
        if (mem[0][2] & 128) v = ((i / b) % 2) ? 255 : 0;
        else v = (i / barLen < n) ? i / barLen : n - 1;
        return (i == lineLen - 1) ? v + 256 : v;
    endfunction : expByte

    always @(negedge sys_clk) begin
        pixReady <= readyMode == 2 ? 1'b0 : (readyMode == 1 ? 1'($urandom % 2) : 1'b1);
    end

    always @(posedge sys_clk) begin
        if (!streamChk) begin
            pos = 0;
            taken = 0;
        end else if (pixValid === 1'b1 && pixReady === 1'b1) begin
            check({7'h00, pixLast, pixData}, expByte(pos));
            pos = (pos + 1) % lineLen;
            taken++;
        end
    end

    task automatic runStream(input int cfg);
        streamChk = 1'b0;
        readyMode = 0;
        lineLen = 9 + $urandom % 12;
        barLen = 1 + $urandom % 4;
        sel(0, 1);
        setoff(1);
        dwr(8'h00);
        dwr(8'(cfg));
        dwr(8'($urandom));
        dwr(8'(lineLen >> 8));
        dwr(8'(lineLen));
        dwr(8'h00);
        dwr(8'(barLen));
        chkOuts();
        for (int i = 0; i < 50 && pixValid !== 1'b0; i++) @(negedge sys_clk);
        streamChk = 1'b1;
        setoff(1);
        dwr(8'h01);
        // long stall so the buffer fills and the generator must hold
        readyMode = 2;
        repeat (20) @(negedge sys_clk);
        check({7'h00, pixLast, pixData}, expByte(0));
        readyMode = 1;
        for (int i = 0; i < 2000 && taken < 2 * lineLen; i++) @(negedge sys_clk);
        check({15'h0000, taken >= 2 * lineLen}, 1);
        streamChk = 1'b0;
    endtask : runStream

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    initial begin
        #(25 * 60000);
        mismatches++;
        print_verdict();
    end

    initial begin
        void'($urandom(75));
        sys_rst = 1'b1;
        readyMode = 0;
        streamChk = 1'b0;
        mismatches = 0;
        compares = 0;
        foreach (mem[p, o]) mem[p][o] = 0;
        mem[0][2] = 8'h33;
        mem[0][3] = 8'h24;
        mem[0][4] = 8'h07;
        mem[0][5] = 8'h80;
        mem[0][7] = 8'hF0;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst = 1'b0;

        chkOuts();
        host.rd(`IAPG_ADDR_CTL, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256);
        host.rd(8'hB3, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256);
        sel(0, 1);
        setoff(0);
        for (int o = 0; o < 8; o++) drd();
        host.rd(`IAPG_ADDR_OFF, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256 + 8);
        $display("test reset values done");

        for (int p = 0; p < 16; p++) begin
            sel(p, 0);
            foreach (offs[i]) if (p != 0 || offs[i] == 0 || offs[i] > 7) begin
                setoff(offs[i]);
                dwr(8'($urandom));
                drd();
            end
        end
        for (int p = 0; p < 16; p++) begin
            sel(p, 0);
            foreach (offs[i]) begin
                setoff(offs[i]);
                drd();
            end
        end
        host.rd(`IAPG_ADDR_CTL, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256 + ctl);
        $display("test page map done");

        sel(0, 1);
        setoff(8'h1C);
        repeat (6) dwr(8'($urandom));
        setoff(8'h1C);
        repeat (6) drd();
        host.rd(`IAPG_ADDR_OFF, rdVal, rdOk);
        check({7'h00, rdOk, rdVal}, 256 + 8'h22);
        sel(7, 1);
        setoff(8'hFF);
        repeat (3) dwr(8'($urandom));
        setoff(8'hFF);
        repeat (3) drd();
        $display("test auto increment done");

        for (int k = 0; k < 6; k++) begin
            runStream((k >= 4) * 128 + (k % 4) * 16 + 1 + $urandom % 15);
        end
        $display("test pattern stream done");
        print_verdict();
    end
endmodule : tb

`default_nettype wire
